// *** hdl/osdpc_pkg.sv ***
package osdpc_pkg;

  // register offsets inside page 6
  localparam logic [5:0] OFS_VSTART = 6'h10;
  localparam logic [5:0] OFS_HSTART = 6'h11;
  localparam logic [5:0] OFS_LGAP = 6'h12;
  localparam logic [5:0] OFS_WGAP = 6'h13;
  localparam logic [5:0] OFS_MASTER = 6'h17;
  localparam logic [5:0] OFS_RAM_HI_LAST = 6'h0F;
  localparam logic [6:0] RAM_HI_BASE = 7'h40;

  // field positions
  localparam int FLD_LSB = 0;
  localparam int FLD_MSB = 5;
  localparam int BIT_AUX = 6;
  localparam int BIT_GSIZE_HI = 7;
  localparam int BIT_ENABLE = 0;

  // reset values of the write-only registers
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic RST_ENABLE = 1'b0;

  // timing
  localparam int CLK_NS = 20;
  localparam int DOT_NS = 400;
  localparam int DOT_CYC = (DOT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] HSTART_BASE = 7'h0A;
  localparam int LINE_STEP = 4;
  localparam int CHAR_H_BASE = 18;
  localparam int CHAR_W_BASE = 6;

  typedef struct packed {
    logic page5;
    logic page6;
    logic [5:0] addr;
    logic [7:0] data;
  } osdpc_wr_t;

  typedef struct packed {
    logic outline_background_select;
    logic [5:0] vertical_start_position;
    logic space_blanking_disable;
    logic [5:0] horizontal_start_position;
    logic screen_blank_force;
    logic [5:0] line_gap_value;
    logic [1:0] global_char_size;
    logic [5:0] word_gap_value;
  } osdpc_cfg_t;

  typedef enum logic [1:0] {
    OSC_OFF = 2'b00,
    OSC_ARMED = 2'b01,
    OSC_RUN = 2'b10
  } osdpc_osc_t;

  // size multiplier from global size bits and per-line size bit
  function automatic logic [2:0] osdpc_mult(input logic [1:0] gs, input logic s);
    logic [2:0] m;
    m = 3'h1;
    case ({gs, s})
      3'b001: m = 3'h2;
      3'b011: m = 3'h3;
      3'b100: m = 3'h2;
      3'b101: m = 3'h3;
      3'b110: m = 3'h2;
      3'b111: m = 3'h4;
      default: m = 3'h1;
    endcase
    return m;
  endfunction : osdpc_mult

endpackage : osdpc_pkg

// *** hdl/osdpc_sync.sv ***
`timescale 1ns/1ps
module osdpc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // asynchronous pins
  input wire logic [W-1:0] i_d,
  // synchronised level and rising edge
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise = sync_q & ~last_q;

endmodule : osdpc_sync

// *** hdl/osdpc_ctrl.sv ***
`timescale 1ns/1ps
// How it works
// - master enable register at 17h is writable at any time.
// - enable low: nothing shown, core may write RAM and all registers.
// - enable high: word visibility per word bit; RAM and registers locked.
// - select bit 0 gives 7x9 box background, 1 gives outline; word enables apply.
// - first text line starts at vertical field times 4 scan lines.
// - first character starts at two oscillator periods times (10 + field).
// - space blanking disable 1 hides background on spaces; 0 follows enables.
// - force 0: blank output only while drawing; 1: always, characters still drawn.
// - blank force works even while master enable is clear.
// - gap enable set: line gap is 6-bit value times 4 scan lines.
// - gap enable clear: no extra lines between text lines.
// - size from global bits and line bit: 18H/6 up to 72H/24.
// - word gap enable: space width plus two periods times (1 + value).
// - extra word gap scales by one to four with character size.
// - word gap enable clear: gap is the space width only.
// - oscillator starts at next vertical sync after enable, stops at once on clear.
module osdpc_ctrl (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // core paged data memory write
  input wire logic i_wr_stb,
  input wire osdpc_pkg::osdpc_wr_t i_wr,
  // video sync pins
  input wire logic i_vsync,
  input wire logic i_hsync,
  // current line and word attributes from the character fetch
  input wire logic i_line_size_bit,
  input wire logic i_line_gap_enable,
  input wire logic i_word_gap_enable,
  input wire logic i_word_visible,
  input wire logic i_bg_enable,
  input wire logic i_space_active,
  input wire logic i_char_active,
  // display RAM write port
  output logic o_ram_we,
  output logic [6:0] o_ram_addr,
  output logic [6:0] o_ram_wdata,
  output logic o_wr_refused,
  // oscillator and timing marks
  output logic o_display_master_enable,
  output logic o_osc_run,
  output logic o_dot_tick,
  output logic o_vstart_hit,
  output logic o_hstart_hit,
  // geometry for the character fetch
  output logic [7:0] o_vstart_lines,
  output logic [7:0] o_hstart_osc,
  output logic [7:0] o_line_gap_lines,
  output logic [6:0] o_char_height,
  output logic [4:0] o_char_width,
  output logic [8:0] o_word_gap_dots,
  // video outputs
  output logic o_box_bg,
  output logic o_outline_bg,
  output logic o_bg_show,
  output logic o_fg_show,
  output logic o_blank_output
);
  import osdpc_pkg::*;

  osdpc_cfg_t cfg_q;
  osdpc_cfg_t cfg_d;
  logic enable_q;
  osdpc_osc_t osc_q;
  osdpc_osc_t osc_d;

  // sync pins, two flops before use
  logic vs_rise;
  logic hs_rise;

  osdpc_sync #(
    .W(2)
  ) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d({i_vsync, i_hsync}),
    .o_level(),
    .o_rise({vs_rise, hs_rise})
  );

  // address decode
  wire hit_ram_lo = i_wr.page5;
  wire hit_ram_hi = i_wr.page6 && (i_wr.addr <= OFS_RAM_HI_LAST);
  wire hit_vstart = i_wr.page6 && (i_wr.addr == OFS_VSTART);
  wire hit_hstart = i_wr.page6 && (i_wr.addr == OFS_HSTART);
  wire hit_lgap = i_wr.page6 && (i_wr.addr == OFS_LGAP);
  wire hit_wgap = i_wr.page6 && (i_wr.addr == OFS_WGAP);
  wire hit_master = i_wr.page6 && (i_wr.addr == OFS_MASTER);
  wire hit_locked = hit_ram_lo || hit_ram_hi || hit_vstart || hit_hstart || hit_lgap || hit_wgap;

  // master enable is never locked; everything else only while it is clear
  wire wr_master = i_wr_stb && hit_master;
  wire wr_open = i_wr_stb && !enable_q;
  wire wr_block = i_wr_stb && enable_q && hit_locked;
  wire wr_ram = wr_open && (hit_ram_lo || hit_ram_hi);

  // each register is replaced whole, never merged bitwise
  always_comb begin
    cfg_d = cfg_q;
    if (wr_open && hit_vstart) begin
      cfg_d.outline_background_select = i_wr.data[BIT_AUX];
      cfg_d.vertical_start_position = i_wr.data[FLD_MSB:FLD_LSB];
    end
    if (wr_open && hit_hstart) begin
      cfg_d.space_blanking_disable = i_wr.data[BIT_AUX];
      cfg_d.horizontal_start_position = i_wr.data[FLD_MSB:FLD_LSB];
    end
    if (wr_open && hit_lgap) begin
      cfg_d.screen_blank_force = i_wr.data[BIT_AUX];
      cfg_d.line_gap_value = i_wr.data[FLD_MSB:FLD_LSB];
    end
    if (wr_open && hit_wgap) begin
      cfg_d.global_char_size = i_wr.data[BIT_GSIZE_HI:BIT_AUX];
      cfg_d.word_gap_value = i_wr.data[FLD_MSB:FLD_LSB];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_q <= osdpc_cfg_t'({RST_REG[6:0], RST_REG[6:0], RST_REG[6:0], RST_REG});
      enable_q <= RST_ENABLE;
    end else begin
      cfg_q <= cfg_d;
      if (wr_master) begin
        enable_q <= i_wr.data[BIT_ENABLE];
      end
    end
  end

  // RAM write port, registered
  wire [6:0] ram_index = hit_ram_lo ? {1'b0, i_wr.addr} : (RAM_HI_BASE | {1'b0, i_wr.addr});

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ram_we <= 1'b0;
      o_ram_addr <= 7'h00;
      o_ram_wdata <= 7'h00;
      o_wr_refused <= 1'b0;
    end else begin
      o_ram_we <= wr_ram;
      o_wr_refused <= wr_block;
      if (wr_ram) begin
        o_ram_addr <= ram_index;
        o_ram_wdata <= i_wr.data[6:0];
      end
    end
  end

  // oscillator control: arm on enable, run from the next vertical sync
  wire enable_next = wr_master ? i_wr.data[BIT_ENABLE] : enable_q;

  always_comb begin
    osc_d = osc_q;
    case (osc_q)
      OSC_OFF: begin
        if (enable_next) begin
          osc_d = OSC_ARMED;
        end
      end
      OSC_ARMED: begin
        if (!enable_next) begin
          osc_d = OSC_OFF;
        end else if (vs_rise) begin
          osc_d = OSC_RUN;
        end
      end
      OSC_RUN: begin
        if (!enable_next) begin
          osc_d = OSC_OFF;
        end
      end
      default: begin
        osc_d = OSC_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      osc_q <= OSC_OFF;
    end else begin
      osc_q <= osc_d;
    end
  end

  wire running = (osc_q == OSC_RUN);

  // dot prescaler: a dot is two oscillator periods, 400 ns
  localparam int PRE_W = $clog2(DOT_CYC);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(DOT_CYC - 1);
  logic [PRE_W-1:0] pre_q;
  logic [6:0] dot_q;
  logic [9:0] line_q;

  wire dot_tick = running && (pre_q == PRE_LAST);
  wire [6:0] hstart_dots = HSTART_BASE + {1'b0, cfg_q.horizontal_start_position};
  wire [9:0] vstart_line = {2'b00, cfg_q.vertical_start_position, 2'b00};

  // prescaler and dot counter restart on each line sync, line counter on vertical sync; nothing counts while the oscillator is off
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_q <= '0;
      dot_q <= 7'h00;
      line_q <= 10'h000;
    end else if (!running) begin
      pre_q <= '0;
      dot_q <= 7'h00;
      line_q <= 10'h000;
    end else begin
      if (hs_rise || dot_tick) begin
        pre_q <= '0;
      end else begin
        pre_q <= pre_q + PRE_W'(1);
      end
      if (hs_rise) begin
        dot_q <= 7'h00;
      end else if (dot_tick && dot_q != 7'h7F) begin
        dot_q <= dot_q + 7'h01;
      end
      if (vs_rise) begin
        line_q <= 10'h000;
      end else if (hs_rise && line_q != 10'h3FF) begin
        line_q <= line_q + 10'h001;
      end
    end
  end

  // geometry
  wire [2:0] mult = osdpc_mult(cfg_q.global_char_size, i_line_size_bit);
  wire [6:0] char_h = 7'(CHAR_H_BASE * mult);
  wire [4:0] char_w = 5'(CHAR_W_BASE * mult);
  wire [8:0] extra_dots = 9'(({3'b000, cfg_q.word_gap_value} + 9'h001) * mult);
  wire [8:0] word_gap = {4'h0, char_w} + (i_word_gap_enable ? extra_dots : 9'h000);
  wire [7:0] line_gap = i_line_gap_enable ? 8'(cfg_q.line_gap_value * LINE_STEP) : 8'h00;

  // drawing gated by the running oscillator; blank force bypasses it
  wire shown = running && i_word_visible;
  wire bg_now = shown && i_bg_enable && !(i_space_active && cfg_q.space_blanking_disable);
  wire fg_now = shown && i_char_active && !i_space_active;
  wire blank_now = cfg_q.screen_blank_force || (running && i_char_active);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dot_tick <= 1'b0;
      o_vstart_hit <= 1'b0;
      o_hstart_hit <= 1'b0;
      o_vstart_lines <= 8'h00;
      o_hstart_osc <= 8'h00;
      o_line_gap_lines <= 8'h00;
      o_char_height <= 7'h00;
      o_char_width <= 5'h00;
      o_word_gap_dots <= 9'h000;
      o_box_bg <= 1'b0;
      o_outline_bg <= 1'b0;
      o_bg_show <= 1'b0;
      o_fg_show <= 1'b0;
      o_blank_output <= 1'b0;
    end else begin
      o_dot_tick <= dot_tick;
      o_vstart_hit <= hs_rise && running && (line_q == vstart_line);
      o_hstart_hit <= dot_tick && (dot_q == hstart_dots);
      o_vstart_lines <= vstart_line[7:0];
      o_hstart_osc <= {hstart_dots, 1'b0};
      o_line_gap_lines <= line_gap;
      o_char_height <= char_h;
      o_char_width <= char_w;
      o_word_gap_dots <= word_gap;
      o_box_bg <= bg_now && !cfg_q.outline_background_select;
      o_outline_bg <= bg_now && cfg_q.outline_background_select;
      o_bg_show <= bg_now;
      o_fg_show <= fg_now;
      o_blank_output <= blank_now;
    end
  end

  assign o_display_master_enable = enable_q;
  assign o_osc_run = running;

endmodule : osdpc_ctrl

// *** tb/osdpc_ctrl_asserts.sv ***
`timescale 1ns/1ps
module osdpc_ctrl_asserts import osdpc_pkg::*; (
  // clock, reset, write bus
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_wr_stb,
  input wire osdpc_pkg::osdpc_wr_t i_wr,
  // attributes
  input wire logic i_line_gap_enable,
  input wire logic i_word_visible,
  input wire logic i_char_active,
  // outputs
  input wire logic o_ram_we,
  input wire logic [6:0] o_ram_addr,
  input wire logic [6:0] o_ram_wdata,
  input wire logic o_wr_refused,
  input wire logic o_display_master_enable,
  input wire logic o_osc_run,
  input wire logic [7:0] o_vstart_lines,
  input wire logic [7:0] o_hstart_osc,
  input wire logic [7:0] o_line_gap_lines,
  input wire logic [6:0] o_char_height,
  input wire logic [4:0] o_char_width,
  input wire logic o_box_bg,
  input wire logic o_outline_bg,
  input wire logic o_bg_show,
  input wire logic o_fg_show,
  input wire logic o_blank_output
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire free = !o_display_master_enable;
  wire p6w = i_wr_stb && i_wr.page6 && !i_wr.page5;

  a_ram_accept: assert property (free && i_wr_stb && i_wr.page5 |=> o_ram_we &&
    o_ram_addr == {1'b0, $past(i_wr.addr)} && o_ram_wdata == $past(i_wr.data[6:0])) else $error("ram write lost");
  a_lock_refuse: assert property (!free && i_wr_stb && i_wr.page5 |=> o_wr_refused && !o_ram_we)
    else $error("locked write taken");
  a_vstart_scale: assert property (free && p6w && i_wr.addr == OFS_VSTART |-> ##2
    o_vstart_lines == {$past(i_wr.data[5:0], 2), 2'b00}) else $error("vertical start wrong");
  a_hstart_scale: assert property (free && p6w && i_wr.addr == OFS_HSTART |-> ##2
    o_hstart_osc == 8'h02 * ({2'b00, $past(i_wr.data[5:0], 2)} + 8'h0A)) else $error("horizontal start wrong");
  a_force_blank: assert property (free && p6w && i_wr.addr == OFS_LGAP && i_wr.data[6] |-> ##2
    o_blank_output) else $error("forced blank missing");
  a_osc_stop: assert property (p6w && i_wr.addr == OFS_MASTER && !i_wr.data[0] |=> !o_osc_run)
    else $error("oscillator still running");
  a_osc_gated: assert property (free |-> !o_osc_run) else $error("oscillator without enable");
  a_draw_blank: assert property (o_osc_run && i_char_active |=> o_blank_output)
    else $error("blank missing while drawing");
  a_hidden_word: assert property (!i_word_visible |=> !o_fg_show && !o_bg_show)
    else $error("hidden word shown");
  a_bg_split: assert property (o_bg_show |-> o_box_bg != o_outline_bg)
    else $error("background kind wrong");
  a_no_line_gap: assert property (!i_line_gap_enable |=> o_line_gap_lines == 8'h00)
    else $error("line gap without enable");
  a_size_ratio: assert property (o_char_height == 3 * o_char_width)
    else $error("size ratio wrong");
endmodule : osdpc_ctrl_asserts

bind osdpc_ctrl osdpc_ctrl_asserts u_asserts (.i_clk, .i_rstn, .i_wr_stb, .i_wr, .i_line_gap_enable,
  .i_word_visible, .i_char_active, .o_ram_we, .o_ram_addr, .o_ram_wdata, .o_wr_refused,
  .o_display_master_enable, .o_osc_run, .o_vstart_lines, .o_hstart_osc, .o_line_gap_lines,
  .o_char_height, .o_char_width, .o_box_bg, .o_outline_bg, .o_bg_show, .o_fg_show, .o_blank_output);

// *** tb/osdpc_core_model.sv ***
`timescale 1ns/1ps
module osdpc_core_model import osdpc_pkg::*; (
  // clock
  input wire logic i_clk,
  // paged data memory write
  output logic o_wr_stb,
  output osdpc_pkg::osdpc_wr_t o_wr
);
  initial begin
    o_wr_stb = 1'b0;
    o_wr = '0;
  end
  // whole bytes only, since nothing can be read back to merge bits
  task automatic wr(input logic p5, input logic [5:0] a, input logic [7:0] d);
    if (!p5 && a == OFS_VSTART && d[5:0] == 6'h00) d[0] = 1'b1;
    @(posedge i_clk);
    o_wr_stb <= 1'b1;
    o_wr <= '{page5: p5, page6: !p5, addr: a, data: d};
    @(posedge i_clk);
    o_wr_stb <= 1'b0;
    o_wr.data <= ~d;
  endtask : wr
endmodule : osdpc_core_model

// *** tb/test_osd_position_spacing_control.sv ***
`timescale 1ns/1ps
module test_osd_position_spacing_control;
  import osdpc_pkg::*;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_vsync = 1'b0, i_line_gap_enable = 1'b1, i_word_gap_enable = 1'b1;
  logic i_hsync = 1'b0, i_line_size_bit = 1'b0;
  logic i_word_visible = 1'b0, i_bg_enable = 1'b0, i_space_active = 1'b0, i_char_active = 1'b0;
  logic i_wr_stb, o_ram_we, o_wr_refused, o_osc_run, o_outline_bg, o_bg_show, o_fg_show, o_blank_output;
  logic o_display_master_enable, o_dot_tick, o_vstart_hit, o_hstart_hit, o_box_bg;
  osdpc_wr_t i_wr;
  logic [6:0] o_ram_addr, o_ram_wdata, o_char_height;
  logic [7:0] o_vstart_lines, o_hstart_osc, o_line_gap_lines;
  logic [4:0] o_char_width;
  logic [8:0] o_word_gap_dots;
  int failures = 0, comparisons = 0, cycles = 0;

  osdpc_core_model core (.i_clk, .o_wr_stb(i_wr_stb), .o_wr(i_wr));
  osdpc_ctrl DUT (.i_clk, .i_rstn, .i_wr_stb, .i_wr, .i_vsync, .i_hsync, .i_line_size_bit,
    .i_line_gap_enable, .i_word_gap_enable, .i_word_visible, .i_bg_enable, .i_space_active, .i_char_active,
    .o_ram_we, .o_ram_addr, .o_ram_wdata, .o_wr_refused, .o_display_master_enable, .o_osc_run,
    .o_dot_tick, .o_vstart_hit, .o_hstart_hit, .o_vstart_lines, .o_hstart_osc, .o_line_gap_lines,
    .o_char_height, .o_char_width, .o_word_gap_dots, .o_box_bg, .o_outline_bg, .o_bg_show, .o_fg_show,
    .o_blank_output);

  initial forever #10 i_clk = ~i_clk;

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // visible, bg enable, char, space
  task automatic vid(input logic [3:0] v);
    @(posedge i_clk);
    {i_word_visible, i_bg_enable, i_char_active, i_space_active} <= v;
    step(2);
  endtask : vid

  task automatic t_ram;
    core.wr(1'b1, 6'h02, 8'h41);
    #1;
    chk({o_ram_we, o_ram_addr, o_ram_wdata}, {1'b1, 7'h02, 7'h41});
    core.wr(1'b0, 6'h0F, 8'h7F);
    #1;
    chk({o_ram_we, o_ram_addr}, {1'b1, 7'h4F});
    $display("ram test done");
  endtask : t_ram

  task automatic t_cfg;
    core.wr(1'b0, OFS_VSTART, 8'h45);
    core.wr(1'b0, OFS_HSTART, 8'h7F);
    core.wr(1'b0, OFS_LGAP, 8'h03);
    core.wr(1'b0, OFS_WGAP, 8'hC5);
    step(3);
    chk(o_vstart_lines, 8'h14);
    chk(o_hstart_osc, 8'h92);
    chk(o_line_gap_lines, 8'h0C);
    chk({o_char_height, o_char_width}, {7'h24, 5'h0C});
    chk(o_word_gap_dots, 9'h018);
    @(posedge i_clk);
    i_line_gap_enable <= 1'b0;
    i_word_gap_enable <= 1'b0;
    step(3);
    chk(o_line_gap_lines, 8'h00);
    chk(o_word_gap_dots, 9'h00C);
    // largest size: both global bits and the line bit set
    @(posedge i_clk);
    i_line_size_bit <= 1'b1;
    i_word_gap_enable <= 1'b1;
    step(3);
    chk({o_char_height, o_char_width}, {7'h48, 5'h18});
    chk(o_word_gap_dots, 9'h030);
    $display("config test done");
  endtask : t_cfg

  // oscillator running, vertical start 5, horizontal start 63, no line sync seen yet
  task automatic t_timing;
    int ticks;
    int hit_at;
    ticks = 0;
    hit_at = 0;
    repeat (200) begin
      step(1);
      if (o_dot_tick === 1'b1) begin
        ticks++;
      end
    end
    chk(ticks, 10);
    // line count starts at 0, so the 21st rising edge finds line 20
    for (int k = 1; k <= 24; k++) begin
      @(posedge i_clk);
      i_hsync <= 1'b1;
      step(3);
      if (o_vstart_hit === 1'b1) begin
        hit_at = k;
      end
      @(posedge i_clk);
      i_hsync <= 1'b0;
      step(2);
    end
    chk(hit_at, 21);
    // pin to dot reset takes three edges, then 20 clocks a dot; hit on the tick that ends dot 73
    @(posedge i_clk);
    i_hsync <= 1'b1;
    step(1482);
    chk(o_hstart_hit, 1'b0);
    step(1);
    chk(o_hstart_hit, 1'b1);
    $display("timing test done");
  endtask : t_timing

  task automatic t_lock;
    core.wr(1'b0, OFS_MASTER, 8'h01);
    #1;
    chk(o_display_master_enable, 1'b1);
    core.wr(1'b0, OFS_VSTART, 8'h07);
    #1;
    chk(o_wr_refused, 1'b1);
    core.wr(1'b1, 6'h03, 8'h55);
    #1;
    chk({o_wr_refused, o_ram_we, o_ram_addr}, {2'b10, 7'h4F});
    step(40);
    chk(o_osc_run, 1'b0);
    @(posedge i_clk) i_vsync <= 1'b1;
    step(6);
    chk({o_osc_run, o_vstart_lines}, {1'b1, 8'h14});
    vid(4'hE);
    chk({o_fg_show, o_bg_show, o_outline_bg, o_blank_output}, 4'hF);
    vid(4'hF);
    chk({o_fg_show, o_bg_show}, 2'b00);
    vid(4'h6);
    chk({o_fg_show, o_bg_show, o_blank_output}, 3'b001);
    t_timing();
    core.wr(1'b0, OFS_MASTER, 8'h00);
    #1;
    chk({o_osc_run, o_display_master_enable}, 2'b00);
    $display("lock test done");
  endtask : t_lock

  task automatic t_blank;
    vid(4'h0);
    core.wr(1'b0, OFS_LGAP, 8'h43);
    step(3);
    chk({o_blank_output, o_osc_run}, 2'b10);
    // box background needs outline select clear and a fresh vertical sync
    @(posedge i_clk) i_vsync <= 1'b0;
    step(3);
    core.wr(1'b0, OFS_VSTART, 8'h05);
    core.wr(1'b0, OFS_MASTER, 8'h01);
    @(posedge i_clk) i_vsync <= 1'b1;
    step(6);
    vid(4'hC);
    chk({o_box_bg, o_outline_bg, o_bg_show, o_blank_output}, 4'hB);
    $display("blank test done");
  endtask : t_blank

  task automatic summarize;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // hang guard, a few times the expected run length
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_ram();
    t_cfg();
    t_lock();
    t_blank();
    summarize();
  end
endmodule : test_osd_position_spacing_control
